// *** include/spfc_regs.svh ***
// register offsets, field positions and reset values of the serial queue block
`ifndef SPFC_REGS_SVH
`define SPFC_REGS_SVH

// register byte offsets on the apb bus
`define SPFC_OFF_STATUS   8'h00
`define SPFC_OFF_RXDATA   8'h04
`define SPFC_OFF_TXDATA   8'h08
`define SPFC_OFF_KERNEL_CLOCK_SOURCE   8'h0C
`define SPFC_OFF_IRQSTAT  8'h10
`define SPFC_OFF_IRQMASK  8'h14
`define SPFC_OFF_CTRL2    8'h18

// status register field positions
`define SPFC_ST_TX_OVERWRITE_ERROR      7
`define SPFC_ST_TX_QUEUE_EMPTY_FLAG      5
`define SPFC_ST_RX_UNDERREAD_ERROR      3
`define SPFC_ST_FLUSH_QUEUES     2
`define SPFC_ST_RX_QUEUE_FULL_FLAG      0

// control two field positions
`define SPFC_C2_BUSY      7
`define SPFC_C2_TXR       1
`define SPFC_C2_RXR       0

// interrupt status and mask field positions
`define SPFC_IRQ_TXOVW    0
`define SPFC_IRQ_RXUND    1
`define SPFC_IRQ_DONE     2

// kernel clock source codes
`define SPFC_CK_SYSOSC    4'h0
`define SPFC_CK_HFOSC     4'h1
`define SPFC_CK_MFOSC     4'h2
`define SPFC_CK_REFOUT    4'h3
`define SPFC_CK_TMR0OVF   4'h4
`define SPFC_CK_TMR2PS    4'h5
`define SPFC_CK_TMR4PS    4'h6
`define SPFC_CK_TMR6PS    4'h7
`define SPFC_CK_SIGMATCH  4'h8

// reset values and field widths
`define SPFC_RST_KERNEL_CLOCK_SOURCE   4'h0
`define SPFC_RST_CTRL2    2'h0
`define SPFC_RST_IRQ      3'h0
`define SPFC_RST_BYTE     8'h00
`define SPFC_RST_WORD     32'h0000_0000
`define SPFC_BITS_LAST    3'h7

`endif

// *** include/spfc_pkg.sv ***
// types shared by the serial queue block
package spfc_pkg;

	// link byte engine states
	typedef enum logic [2:0] {
		SPFC_LS_IDLE  = 3'b001,
		SPFC_LS_LOAD  = 3'b010,
		SPFC_LS_SHIFT = 3'b100
	} spfc_link_state_t;

	// events that feed the sticky interrupt status
	typedef struct packed {
		logic byte_done;
		logic rx_underread;
		logic tx_overwrite;
	} spfc_evt_t;

	// synchronised link pins
	typedef struct packed {
		logic sclk;
		logic ssn;
		logic sdi;
	} spfc_link_t;

endpackage

// *** rtl/spfc_sync.sv ***
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ns

module spfc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,   // system clock
	input  wire logic         i_rstn,  // synchronous reset, active low
	input  wire logic [W-1:0] i_async, // levels from another domain
	output logic      [W-1:0] o_sync   // levels safe to read
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

// *** rtl/spfc_queue.sv ***
// small byte queue with occupancy counter, flush and honest empty/full
`timescale 1ns/1ns

module spfc_queue #(
	parameter int W     = 8,
	parameter int DEPTH = 2,
	localparam int PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1,
	localparam int CW   = $clog2(DEPTH + 1)
) (
	input  wire logic          i_clk,   // system clock
	input  wire logic          i_rstn,  // synchronous reset, active low
	input  wire logic          i_flush, // empties the queue
	input  wire logic          i_push,  // append i_din, ignored when full
	input  wire logic [W-1:0]  i_din,   // byte to append
	input  wire logic          i_pop,   // remove head, ignored when empty
	output logic      [W-1:0]  o_dout,  // head byte
	output logic               o_empty, // no entry held
	output logic               o_full,  // every entry held
	output logic      [CW-1:0] o_count  // occupancy
);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic          do_push;
	logic          do_pop;

	// flags come from the counter so they never disagree with it
	assign o_empty = (o_count == '0);
	assign o_full  = (o_count == CW'(DEPTH));
	assign do_push = i_push && !o_full;
	assign do_pop  = i_pop && !o_empty;
	assign o_dout  = mem[rp_q];

	// storage, no reset needed since the counter guards reads
	always_ff @(posedge i_clk) begin
		if (do_push && !i_flush) begin
			mem[wp_q] <= i_din;
		end
	end

	// pointers and occupancy; flush beats a simultaneous push or pop
	always_ff @(posedge i_clk) begin
		if (!i_rstn || i_flush) begin
			wp_q    <= '0;
			rp_q    <= '0;
			o_count <= '0;
		end else begin
			if (do_push) begin
				wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (do_pop) begin
				rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				o_count <= o_count + 1'b1;
			end else if (do_pop && !do_push) begin
				o_count <= o_count - 1'b1;
			end
		end
	end

endmodule

// *** rtl/spfc_top.sv ***
// serial queue block: apb registers, byte queues, link byte engine, clock select
`timescale 1ns/1ns
`include "spfc_regs.svh"

module spfc_top #(
	parameter int DEPTH = 2,
	parameter int NSRC  = 9,
	localparam int CW   = $clog2(DEPTH + 1)
) (
	input  wire logic            i_clk,        // system clock, 25 MHz
	input  wire logic            i_rstn,       // synchronous reset, active low
	input  wire logic            i_psel,       // apb select
	input  wire logic            i_penable,    // apb access phase
	input  wire logic            i_pwrite,     // apb direction, high for write
	input  wire logic [7:0]      i_paddr,      // apb byte address
	input  wire logic [31:0]     i_pwdata,     // apb write data
	input  wire logic [3:0]      i_pstrb,      // apb byte strobes
	output logic      [31:0]     o_prdata,     // apb read data
	output logic                 o_pready,     // apb ready
	output logic                 o_pslverr,    // apb error on unmapped address
	input  wire logic            i_link_sclk,  // link clock from the far end
	input  wire logic            i_link_ssn,   // link frame select, active low
	input  wire logic            i_link_sdi,   // link serial data in
	output logic                 o_link_sdo,   // link serial data out
	input  wire logic [NSRC-1:0] i_clk_src,    // candidate kernel clock sources
	output logic                 o_kernel_clk, // selected kernel clock level
	output logic                 o_irq         // level interrupt
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	spfc_pkg::spfc_link_state_t state_q;
	spfc_pkg::spfc_evt_t        evt;
	spfc_pkg::spfc_link_t       lnk_s;
	logic            sclk_prev_q;
	logic            sclk_rise;
	logic            sclk_fall;
	logic [NSRC-1:0] src_s;
	logic            setup;
	logic            access;
	logic            mapped;
	logic            wr;
	logic            rd;
	logic            rd_empty_q;
	logic [31:0]     rd_mux;
	logic            wr_status;
	logic            wr_tx;
	logic            rd_rx;
	logic            flush;
	logic            tx_overwrite_error_q;
	logic            rx_underread_error_q;
	logic [3:0]      kernel_clock_source_q;
	logic            txr_q;
	logic            rxr_q;
	logic [2:0]      irq_stat_q;
	logic [2:0]      irq_mask_q;
	logic            tx_pop;
	logic            tx_empty;
	logic            tx_full;
	logic [7:0]      tx_dout;
	logic [CW-1:0]   tx_count;
	logic            rx_push;
	logic            rx_pop;
	logic            rx_empty;
	logic            rx_full;
	logic [7:0]      rx_dout;
	logic [CW-1:0]   rx_count;
	logic            stall;
	logic            frame;
	logic [7:0]      shift_tx_q;
	logic [7:0]      shift_rx_q;
	logic [2:0]      bit_cnt_q;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	// select crosses inverted so the synchroniser's reset value reads as no frame
	spfc_sync #(.W(3)) u_link_sync (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_async ({i_link_sclk, !i_link_ssn, i_link_sdi}),
		.o_sync  (lnk_s)
	);

	spfc_sync #(.W(NSRC)) u_src_sync (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_async (i_clk_src),
		.o_sync  (src_s)
	);

	// ****************************************************************
	// apb slave
	// ****************************************************************
	// no wait state: ready rises in the first access cycle so outputs stay registered
	assign setup  = i_psel && !i_penable;
	assign access = i_psel && i_penable && o_pready;
	assign mapped = (i_paddr == `SPFC_OFF_STATUS) || (i_paddr == `SPFC_OFF_RXDATA) ||
	                (i_paddr == `SPFC_OFF_TXDATA) || (i_paddr == `SPFC_OFF_KERNEL_CLOCK_SOURCE) ||
	                (i_paddr == `SPFC_OFF_IRQSTAT) || (i_paddr == `SPFC_OFF_IRQMASK) ||
	                (i_paddr == `SPFC_OFF_CTRL2);
	assign wr        = access && i_pwrite && i_pstrb[0] && mapped;
	assign rd        = access && !i_pwrite && mapped;
	assign wr_status = wr && (i_paddr == `SPFC_OFF_STATUS);
	assign wr_tx     = wr && (i_paddr == `SPFC_OFF_TXDATA);
	assign rd_rx     = rd && (i_paddr == `SPFC_OFF_RXDATA);
	assign flush     = wr_status && i_pwdata[`SPFC_ST_FLUSH_QUEUES];
	// emptiness is frozen at setup so returned data and the pop always agree
	assign rx_pop    = rd_rx && !rd_empty_q;

	// read data mux, narrow registers sit in the low byte
	always_comb begin
		rd_mux = `SPFC_RST_WORD;
		case (i_paddr)
			`SPFC_OFF_STATUS: begin
				rd_mux[`SPFC_ST_TX_OVERWRITE_ERROR] = tx_overwrite_error_q;
				rd_mux[`SPFC_ST_TX_QUEUE_EMPTY_FLAG] = tx_empty;
				rd_mux[`SPFC_ST_RX_UNDERREAD_ERROR] = rx_underread_error_q;
				rd_mux[`SPFC_ST_RX_QUEUE_FULL_FLAG] = rx_full;
			end
			`SPFC_OFF_RXDATA:  rd_mux[7:0] = rx_empty ? `SPFC_RST_BYTE : rx_dout;
			`SPFC_OFF_KERNEL_CLOCK_SOURCE:  rd_mux[3:0] = kernel_clock_source_q;
			`SPFC_OFF_IRQSTAT: rd_mux[2:0] = irq_stat_q;
			`SPFC_OFF_IRQMASK: rd_mux[2:0] = irq_mask_q;
			`SPFC_OFF_CTRL2: begin
				rd_mux[`SPFC_C2_BUSY] = (state_q == spfc_pkg::SPFC_LS_SHIFT);
				rd_mux[`SPFC_C2_TXR]  = txr_q;
				rd_mux[`SPFC_C2_RXR]  = rxr_q;
			end
			default: rd_mux = `SPFC_RST_WORD;
		endcase
	end

	// bus answer flops
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pready   <= 1'b0;
			o_pslverr  <= 1'b0;
			o_prdata   <= `SPFC_RST_WORD;
			rd_empty_q <= 1'b1;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup && !mapped;
			if (setup) begin
				o_prdata   <= i_pwrite ? `SPFC_RST_WORD : rd_mux;
				rd_empty_q <= rx_empty;
			end
		end
	end

	// ****************************************************************
	// status and control registers
	// ****************************************************************
	// sticky errors, write one clears, a same-cycle set wins
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tx_overwrite_error_q <= 1'b0;
			rx_underread_error_q <= 1'b0;
		end else begin
			tx_overwrite_error_q <= (wr_tx && tx_full) ||
			          (tx_overwrite_error_q && !(wr_status && i_pwdata[`SPFC_ST_TX_OVERWRITE_ERROR]));
			rx_underread_error_q <= (rd_rx && rd_empty_q) ||
			          (rx_underread_error_q && !(wr_status && i_pwdata[`SPFC_ST_RX_UNDERREAD_ERROR]));
		end
	end

	// clock select, transfer gating controls and interrupt mask
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			kernel_clock_source_q     <= `SPFC_RST_KERNEL_CLOCK_SOURCE;
			{txr_q, rxr_q} <= `SPFC_RST_CTRL2;
			irq_mask_q   <= `SPFC_RST_IRQ;
		end else if (wr) begin
			if (i_paddr == `SPFC_OFF_KERNEL_CLOCK_SOURCE) begin
				kernel_clock_source_q <= i_pwdata[3:0];
			end
			if (i_paddr == `SPFC_OFF_CTRL2) begin
				txr_q <= i_pwdata[`SPFC_C2_TXR];
				rxr_q <= i_pwdata[`SPFC_C2_RXR];
			end
			if (i_paddr == `SPFC_OFF_IRQMASK) begin
				irq_mask_q <= i_pwdata[2:0];
			end
		end
	end

	// ****************************************************************
	// interrupts
	// ****************************************************************
	assign evt.tx_overwrite = wr_tx && tx_full;
	assign evt.rx_underread = rd_rx && rd_empty_q;

	// sticky event bits, a new event beats the write-one clear
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_stat_q <= `SPFC_RST_IRQ;
			o_irq      <= 1'b0;
		end else begin
			irq_stat_q <= evt | (irq_stat_q &
			              ~(({3{wr && (i_paddr == `SPFC_OFF_IRQSTAT)}}) & i_pwdata[2:0]));
			o_irq      <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ****************************************************************
	// kernel clock select
	// ****************************************************************
	// reserved codes give a quiet low level rather than an arbitrary source
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_kernel_clk <= 1'b0;
		end else begin
			o_kernel_clk <= (32'(kernel_clock_source_q) < NSRC) ? src_s[kernel_clock_source_q] : 1'b0;
		end
	end

	// ****************************************************************
	// queues
	// ****************************************************************
	spfc_queue #(.W(8), .DEPTH(DEPTH)) u_txq (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_flush (flush),
		.i_push  (wr_tx),
		.i_din   (i_pwdata[7:0]),
		.i_pop   (tx_pop),
		.o_dout  (tx_dout),
		.o_empty (tx_empty),
		.o_full  (tx_full),
		.o_count (tx_count)
	);

	spfc_queue #(.W(8), .DEPTH(DEPTH)) u_rxq (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_flush (flush),
		.i_push  (rx_push),
		.i_din   ({shift_rx_q[6:0], lnk_s.sdi}),
		.i_pop   (rx_pop),
		.o_dout  (rx_dout),
		.o_empty (rx_empty),
		.o_full  (rx_full),
		.o_count (rx_count)
	);

	// ****************************************************************
	// link byte engine
	// ****************************************************************
	assign frame     = lnk_s.ssn;
	assign sclk_rise = lnk_s.sclk && !sclk_prev_q;
	assign sclk_fall = !lnk_s.sclk && sclk_prev_q;
	// a byte waits for transmit data only with txr_q set and for receive space only with rxr_q set
	assign stall   = (txr_q && tx_empty) || (rxr_q && rx_full);
	assign tx_pop  = (state_q == spfc_pkg::SPFC_LS_LOAD) && frame && !stall && !tx_empty;
	assign rx_push = (state_q == spfc_pkg::SPFC_LS_SHIFT) && frame && sclk_rise &&
	                 (bit_cnt_q == `SPFC_BITS_LAST) && rxr_q;
	assign evt.byte_done = (state_q == spfc_pkg::SPFC_LS_SHIFT) && frame && sclk_rise &&
	                       (bit_cnt_q == `SPFC_BITS_LAST);

	// edge finder reads only the settled synchroniser output
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= lnk_s.sclk;
		end
	end

	// byte sequencing: sample on rising, drive on falling, msb first
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_q    <= spfc_pkg::SPFC_LS_IDLE;
			shift_tx_q <= `SPFC_RST_BYTE;
			shift_rx_q <= `SPFC_RST_BYTE;
			bit_cnt_q  <= '0;
			o_link_sdo <= 1'b0;
		end else begin
			unique case (state_q)
				spfc_pkg::SPFC_LS_IDLE: begin
					if (frame) begin
						state_q <= spfc_pkg::SPFC_LS_LOAD;
					end
				end
				spfc_pkg::SPFC_LS_LOAD: begin
					if (!frame) begin
						state_q <= spfc_pkg::SPFC_LS_IDLE;
					end else if (!stall) begin
						shift_tx_q <= tx_empty ? `SPFC_RST_BYTE : tx_dout;
						o_link_sdo <= tx_empty ? 1'b0 : tx_dout[7];
						bit_cnt_q  <= '0;
						state_q    <= spfc_pkg::SPFC_LS_SHIFT;
					end
				end
				spfc_pkg::SPFC_LS_SHIFT: begin
					// a frame ending mid-byte drops the partial byte
					if (!frame) begin
						state_q <= spfc_pkg::SPFC_LS_IDLE;
					end else if (sclk_rise) begin
						shift_rx_q <= {shift_rx_q[6:0], lnk_s.sdi};
						bit_cnt_q  <= bit_cnt_q + 1'b1;
						if (bit_cnt_q == `SPFC_BITS_LAST) begin
							state_q <= spfc_pkg::SPFC_LS_LOAD;
						end
					end else if (sclk_fall && (bit_cnt_q != '0)) begin // first fall is the last byte's
						shift_tx_q <= {shift_tx_q[6:0], 1'b0};
						o_link_sdo <= shift_tx_q[6];
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	tx_ovw_flag_a: assert property (wr_tx && tx_full |=> tx_overwrite_error_q)
		else $error("overwrite flag not set");
	tx_empty_src_a: assert property ($fell(tx_empty) |-> $past(wr_tx))
		else $error("transmit queue filled without a write");
	rx_und_flag_a: assert property (rd_rx && rd_empty_q |=> rx_underread_error_q)
		else $error("underread flag not set");
	flush_empty_a: assert property (flush |=> tx_empty && rx_empty)
		else $error("flush left data behind");
	rx_full_src_a: assert property ($rose(rx_full) |-> $past(rx_push))
		else $error("receive queue filled without a push");
	rx_pop_count_a: assert property (rx_pop && !rx_push && !flush |=>
		rx_count == CW'($past(rx_count) - 1'b1))
		else $error("receive read did not remove a byte");
	rx_und_hold_a: assert property (rd_rx && rd_empty_q && !rx_push |->
		(o_prdata == `SPFC_RST_WORD) ##1 (rx_count == $past(rx_count)))
		else $error("empty read changed occupancy");
	tx_push_count_a: assert property (wr_tx && !tx_full && !tx_pop && !flush |=>
		tx_count == CW'($past(tx_count) + 1'b1))
		else $error("transmit write not appended");
	tx_drop_count_a: assert property (wr_tx && tx_full && !tx_pop |=>
		tx_count == $past(tx_count) && tx_full)
		else $error("full transmit write changed the queue");
	clk_sel_low_a: assert property (kernel_clock_source_q < `SPFC_CK_SIGMATCH |=>
		o_kernel_clk == $past(src_s[kernel_clock_source_q]))
		else $error("kernel clock not the selected source");
	clk_sel_rsvd_a: assert property (kernel_clock_source_q > `SPFC_CK_SIGMATCH |=> !o_kernel_clk)
		else $error("reserved clock code drives a clock");
	rx_space_gate_a: assert property (evt.byte_done && !rxr_q && !rx_pop && !flush |=>
		rx_count == $past(rx_count))
		else $error("byte stored while storage disabled");
	tx_need_wait_a: assert property (state_q == spfc_pkg::SPFC_LS_LOAD &&
		txr_q && tx_empty |=> state_q != spfc_pkg::SPFC_LS_SHIFT)
		else $error("byte started without transmit data");
	queue_bound_a: assert property (tx_count <= CW'(DEPTH) && rx_count <= CW'(DEPTH))
		else $error("queue occupancy beyond depth");

endmodule

// *** tb/test_spfc_top.sv ***
// self-checking bench for the serial queue block over apb and the link pins
`timescale 1ns/1ns
`include "spfc_regs.svh"

module test_spfc_top;
	logic        i_clk;
	logic        i_rstn;
	logic        i_psel;
	logic        i_penable;
	logic        i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        i_link_sclk;
	logic        i_link_ssn;
	logic        i_link_sdi;
	logic        o_link_sdo;
	logic [7:0]  so_q;
	logic [8:0]  i_clk_src;
	logic        o_kernel_clk;
	logic        o_irq;
	logic [31:0] rd_q;
	logic        slverr_q;
	logic [8:0]  src;
	int          err_total;
	int          compares;

	spfc_top DUT (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(4'hF),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_link_sclk(i_link_sclk), .i_link_ssn(i_link_ssn), .i_link_sdi(i_link_sdi),
		.o_link_sdo(o_link_sdo), .i_clk_src(i_clk_src), .o_kernel_clk(o_kernel_clk), .o_irq(o_irq)
	);

	// ****************************************
	// clock, 25 MHz
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	// verdict and end of run, also reached by a timeout
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; psel stays up so a back-to-back setup may follow
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		@(posedge i_clk);
		while (o_pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_total++;
				end_sim();
			end
			@(posedge i_clk);
		end
		rd_q = o_prdata;
		slverr_q = o_pslverr;
		i_penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_q, exp);
	endtask

	// idle the bus for a number of cycles
	task automatic cyc(input int n);
		i_psel <= 1'b0;
		repeat (n) @(posedge i_clk);
	endtask

	// one link byte, msb first; the link clock idles low, sdo is taken just before each rise
	task automatic link_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			i_link_sdi <= b[i];
			repeat (4) @(posedge i_clk);
			so_q[i] = o_link_sdo;
			i_link_sclk <= 1'b1;
			repeat (4) @(posedge i_clk);
			i_link_sclk <= 1'b0;
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		err_total = 0;
		compares = 0;
		i_rstn = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		i_link_sclk = 1'b0;
		i_link_ssn = 1'b1;
		i_link_sdi = 1'b0;
		i_clk_src = 9'h000;
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		// reset values, unmapped address
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0020);
		rd_chk(`SPFC_OFF_KERNEL_CLOCK_SOURCE, 32'h0000_0000);
		rd_chk(8'h40, 32'h0000_0000);
		chk(32'(slverr_q), 32'h0000_0001);
		apb(1'b1, `SPFC_OFF_IRQMASK, 32'h0000_0007);
		// fill the transmit queue, then overrun it
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_0011);
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_0022);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0000);
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_0033);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0080);
		chk(32'(o_irq), 32'h0000_0001);
		rd_chk(`SPFC_OFF_IRQSTAT, 32'h0000_0001);
		// clear the error and flush in one write, then a zero write changes nothing
		apb(1'b1, `SPFC_OFF_STATUS, 32'h0000_0084);
		apb(1'b1, `SPFC_OFF_IRQSTAT, 32'h0000_0001);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0020);
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_0044);
		apb(1'b1, `SPFC_OFF_STATUS, 32'h0000_0000);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0000);
		apb(1'b1, `SPFC_OFF_STATUS, 32'h0000_0004);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0020);
		cyc(2);
		chk(32'(o_irq), 32'h0000_0000);
		// underread of the empty receive queue
		rd_chk(`SPFC_OFF_RXDATA, 32'h0000_0000);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0028);
		rd_chk(`SPFC_OFF_IRQSTAT, 32'h0000_0002);
		apb(1'b1, `SPFC_OFF_STATUS, 32'h0000_0008);
		apb(1'b1, `SPFC_OFF_IRQSTAT, 32'h0000_0002);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0020);
		// two link bytes fill the receive queue with space required set; the first
		// carries the one queued transmit byte, the second finds the queue empty
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_005A);
		apb(1'b1, `SPFC_OFF_CTRL2, 32'h0000_0001);
		cyc(1);
		i_link_ssn <= 1'b0;
		repeat (4) @(posedge i_clk);
		link_byte(8'hA5);
		chk(32'(so_q), 32'h0000_005A);
		link_byte(8'h3C);
		chk(32'(so_q), 32'h0000_0000);
		repeat (8) @(posedge i_clk);
		i_link_ssn <= 1'b1;
		i_link_sdi <= 1'b1;
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0021);
		rd_chk(`SPFC_OFF_RXDATA, 32'h0000_00A5);
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0020);
		rd_chk(`SPFC_OFF_RXDATA, 32'h0000_003C);
		rd_chk(`SPFC_OFF_IRQSTAT, 32'h0000_0004);
		// data required holds the byte engine until transmit data arrives, storage off
		apb(1'b1, `SPFC_OFF_IRQSTAT, 32'h0000_0004);
		apb(1'b1, `SPFC_OFF_CTRL2, 32'h0000_0002);
		cyc(1);
		i_link_ssn <= 1'b0;
		repeat (4) @(posedge i_clk);
		link_byte(8'h77);
		rd_chk(`SPFC_OFF_IRQSTAT, 32'h0000_0000);
		rd_chk(`SPFC_OFF_CTRL2, 32'h0000_0002);
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_00C3);
		apb(1'b1, `SPFC_OFF_TXDATA, 32'h0000_0081);
		cyc(0);
		link_byte(8'h96);
		chk(32'(so_q), 32'h0000_00C3);
		link_byte(8'h69);
		chk(32'(so_q), 32'h0000_0081);
		repeat (8) @(posedge i_clk);
		i_link_ssn <= 1'b1;
		rd_chk(`SPFC_OFF_STATUS, 32'h0000_0020);
		rd_chk(`SPFC_OFF_IRQSTAT, 32'h0000_0004);
		// every selector code, valid ones follow their source, reserved read low
		for (int k = 0; k < 16; k++) begin
			apb(1'b1, `SPFC_OFF_KERNEL_CLOCK_SOURCE, 32'(k));
			src = (k < 9) ? (9'h001 << k) : 9'h1FF;
			i_clk_src <= src;
			cyc(6);
			chk(32'(o_kernel_clk), (k < 9) ? 32'h0000_0001 : 32'h0000_0000);
			i_clk_src <= ~src;
			rd_chk(`SPFC_OFF_KERNEL_CLOCK_SOURCE, 32'(k));
			cyc(6);
			chk(32'(o_kernel_clk), 32'h0000_0000);
		end
		end_sim();
	end
endmodule
